// ### logic/eeprom_bus_cond.sv
// Bus condition, bit, acknowledge and write-cycle timing logic of the serial EEPROM slave.
`timescale 1ns/1ns
module eeprom_bus_cond #(
    parameter int WR_CYCLES_PER_PAGE = eeprom_bus_pkg::WRITE_CYCLES_PER_PAGE
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic ack_en,
    input wire logic tx_en,
    input wire logic [7:0] tx_data,
    input wire logic [3:0] wr_pages,
    output eeprom_bus_pkg::rx_byte_s rx_byte,
    output logic tx_load,
    output logic start_seen,
    output logic stop_seen,
    output logic bus_idle,
    output logic wr_busy
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        eeprom_bus_pkg::bus_state_e st;
        logic scl_p;
        logic sda_p;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [5:0] hold_cnt;
        logic hold_run;
        logic pend_oe_n;
        logic oe_n;
        logic acked;
        logic m_ack;
        eeprom_bus_pkg::rx_byte_s rx;
        logic tx_load;
        logic start;
        logic stop;
        logic idle;
        logic busy;
        logic [3:0] page_left;
        logic [23:0] cyc_cnt;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    // The write timer is 24 bits wide and needs at least two cycles per page.
    if (WR_CYCLES_PER_PAGE < 2 || WR_CYCLES_PER_PAGE > 16777215) begin : g_bad_wr_cycles
        $error("eeprom_bus_cond: WR_CYCLES_PER_PAGE out of range");
    end

    eeprom_bus_filter u_scl_filt (
        .clock(clock),
        .nrst(nrst),
        .line_in(scl_in),
        .line_out(scl)
    );

    eeprom_bus_filter u_sda_filt (
        .clock(clock),
        .nrst(nrst),
        .line_in(sda_in),
        .line_out(sda)
    );

    // ************************************************************
    // Edge and condition detection on filtered levels
    // ************************************************************
    assign scl_rise = scl && !s_q.scl_p;
    assign scl_fall = !scl && s_q.scl_p;
    assign start_ev = scl && s_q.scl_p && s_q.sda_p && !sda;
    assign stop_ev = scl && s_q.scl_p && !s_q.sda_p && sda;

    // Every change of the driven line except the release on START or STOP waits out the hold delay after the clock fell, so the
    // master never sees our edge inside its own falling edge and reads it as a condition.
    function automatic state_s sched(input state_s x, input logic drive_high);
        state_s y;
        y = x;
        y.pend_oe_n = drive_high;
        y.hold_cnt = 6'(eeprom_bus_pkg::HOLD_CYCLES);
        y.hold_run = 1'b1;
        return y;
    endfunction : sched

    // Load the next byte to send; its MSB goes out after the hold delay.
    function automatic state_s load_tx(input state_s x, input logic [7:0] d);
        state_s y;
        y = sched(x, d[7]);
        y.shreg = {d[6:0], 1'b0};
        y.bit_cnt = 4'h1;
        y.tx_load = 1'b1;
        y.st = eeprom_bus_pkg::ST_TX;
        return y;
    endfunction : load_tx

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.scl_p = scl;
        s_d.sda_p = sda;
        s_d.rx.valid = 1'b0;
        s_d.tx_load = 1'b0;
        s_d.start = start_ev;
        s_d.stop = stop_ev;
        s_d.idle = scl && sda;

        if (s_q.hold_run) begin
            if (s_q.hold_cnt == 6'h01) begin
                s_d.oe_n = s_q.pend_oe_n;
                s_d.hold_run = 1'b0;
            end else begin
                s_d.hold_cnt = s_q.hold_cnt - 6'h01;
            end
        end

        // Self-timed write: one page period per loaded page.
        if (s_q.busy) begin
            if (s_q.cyc_cnt == 24'h000001) begin
                if (s_q.page_left == 4'h1) begin
                    s_d.busy = 1'b0;
                end else begin
                    s_d.page_left = s_q.page_left - 4'h1;
                    s_d.cyc_cnt = 24'(WR_CYCLES_PER_PAGE);
                end
            end else begin
                s_d.cyc_cnt = s_q.cyc_cnt - 24'h000001;
            end
        end

        if (start_ev) begin
            // A START abandons whatever byte was in flight.
            s_d.st = eeprom_bus_pkg::ST_RX;
            s_d.bit_cnt = 4'h0;
            s_d.oe_n = 1'b1;
            s_d.hold_run = 1'b0;
        end else if (stop_ev) begin
            s_d.st = eeprom_bus_pkg::ST_IDLE;
            s_d.oe_n = 1'b1;
            s_d.hold_run = 1'b0;
            if (!s_q.busy && wr_pages != 4'h0 && wr_pages <= 4'(eeprom_bus_pkg::MAX_PAGES)) begin
                s_d.busy = 1'b1;
                s_d.page_left = wr_pages;
                s_d.cyc_cnt = 24'(WR_CYCLES_PER_PAGE);
            end
        end else begin
            unique case (s_q.st)
                eeprom_bus_pkg::ST_IDLE, eeprom_bus_pkg::ST_IGNORE: begin
                end
                eeprom_bus_pkg::ST_RX: begin
                    if (scl_rise) begin
                        s_d.shreg = {s_q.shreg[6:0], sda};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        if (s_q.bit_cnt == 4'h7) begin
                            s_d.rx.data = {s_q.shreg[6:0], sda};
                            s_d.rx.valid = 1'b1;
                        end
                    end else if (scl_fall && s_q.bit_cnt == 4'h8) begin
                        s_d.acked = ack_en && !s_q.busy;
                        s_d = sched(s_d, !(ack_en && !s_q.busy));
                        s_d.st = eeprom_bus_pkg::ST_ACK;
                        s_d.bit_cnt = 4'h0;
                    end
                end
                eeprom_bus_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (!s_q.acked) begin
                            s_d = sched(s_d, 1'b1);
                            s_d.st = eeprom_bus_pkg::ST_IGNORE;
                        end else if (tx_en) begin
                            s_d = load_tx(s_d, tx_data);
                        end else begin
                            s_d = sched(s_d, 1'b1);
                            s_d.st = eeprom_bus_pkg::ST_RX;
                        end
                    end
                end
                eeprom_bus_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (s_q.bit_cnt == 4'h8) begin
                            s_d = sched(s_d, 1'b1);
                            s_d.st = eeprom_bus_pkg::ST_TX_ACK;
                        end else begin
                            s_d = sched(s_d, s_q.shreg[7]);
                            s_d.shreg = {s_q.shreg[6:0], 1'b0};
                            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        end
                    end
                end
                eeprom_bus_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        s_d.m_ack = !sda;
                    end else if (scl_fall) begin
                        if (s_q.m_ack) begin
                            s_d = load_tx(s_d, tx_data);
                        end else begin
                            // No acknowledge from the master: leave the line high for its STOP.
                            s_d.st = eeprom_bus_pkg::ST_IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{st: eeprom_bus_pkg::ST_IDLE, scl_p: 1'b1, sda_p: 1'b1, bit_cnt: 4'h0,
                     shreg: 8'h00, hold_cnt: 6'h00, hold_run: 1'b0, pend_oe_n: 1'b1, oe_n: 1'b1,
                     acked: 1'b0, m_ack: 1'b0, rx: '0, tx_load: 1'b0, start: 1'b0, stop: 1'b0,
                     idle: 1'b1, busy: 1'b0, page_left: 4'h0, cyc_cnt: 24'h000000};
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Open drain: the level is low whenever the enable is active; while released it is don't-care,
    // so it simply follows the enable register.
    assign sda_out = s_q.oe_n;
    assign sda_oe_n = s_q.oe_n;
    assign rx_byte = s_q.rx;
    assign tx_load = s_q.tx_load;
    assign start_seen = s_q.start;
    assign stop_seen = s_q.stop;
    assign bus_idle = s_q.idle;
    assign wr_busy = s_q.busy;
endmodule : eeprom_bus_cond

// ### logic/eeprom_bus_filter.sv
// Shared constants and types for the two-wire bus condition block, plus the input glitch filter.
package eeprom_bus_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int GLITCH_REJECT_WIDTH_NS = 50;
    // A spike this wide covers at most this many samples; one more is needed to pass.
    localparam int GLITCH_CYCLES = (GLITCH_REJECT_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_STABLE_CYCLES = GLITCH_CYCLES + 1;
    localparam int CLOCK_TO_OUTPUT_DELAY_NS = 300;
    localparam int HOLD_CYCLES = (CLOCK_TO_OUTPUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYCLE_MS = 5;
    localparam int PAGE_BYTES = 8;
    localparam int MAX_PAGES = 8;
    // Longest time, so rounded down.
    localparam int WRITE_CYCLES_PER_PAGE = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic LINE_RESET = 1'b1;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } rx_byte_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } bus_state_e;
endpackage : eeprom_bus_pkg

`timescale 1ns/1ns
module eeprom_bus_filter #(
    parameter int STABLE_CYCLES = eeprom_bus_pkg::FILTER_STABLE_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic line_in,
    output logic line_out
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic [7:0] cnt;
        logic level;
    } filt_s;

    filt_s s_q;
    filt_s s_d;

    // The run counter is eight bits wide, so longer filters cannot be served.
    if (STABLE_CYCLES < 1 || STABLE_CYCLES > 255) begin : g_bad_stable
        $error("eeprom_bus_filter: STABLE_CYCLES out of range");
    end

    // The level moves only after the synchronised input has differed for STABLE_CYCLES samples.
    always_comb begin
        s_d = s_q;
        s_d.meta = line_in;
        s_d.sync = s_q.meta;
        if (s_q.sync == s_q.level) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == 8'(STABLE_CYCLES - 1)) begin
            s_d.level = s_q.sync;
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{meta: eeprom_bus_pkg::LINE_RESET, sync: eeprom_bus_pkg::LINE_RESET,
                     cnt: 8'h00, level: eeprom_bus_pkg::LINE_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign line_out = s_q.level;
endmodule : eeprom_bus_filter

// ### bench/eeprom_bus_cond_sva.sv
// Port-level checker for the two-wire bus condition block.
`timescale 1ns/1ns
module eeprom_bus_cond_sva #(
    parameter int WR_CYCLES_PER_PAGE = 50
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe_n,
    input wire logic [3:0] wr_pages,
    input wire eeprom_bus_pkg::rx_byte_s rx_byte,
    input wire logic start_seen,
    input wire logic stop_seen,
    input wire logic bus_idle,
    input wire logic wr_busy
);
    // ********
    // Run-length helpers
    // ********
    logic [7:0] hi_q, lo_q, sl_q;
    logic [31:0] bc_q;
    logic [3:0] pg_q;
    function automatic logic [7:0] run(input logic c, input logic [7:0] v);
        return c ? v + {7'h00, v != 8'hff} : 8'h00;
    endfunction : run
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            {hi_q, lo_q, sl_q, bc_q, pg_q} <= '0;
        end else begin
            hi_q <= run(scl_in && sda_in, hi_q);
            lo_q <= run(!sda_in, lo_q);
            sl_q <= run(!scl_in, sl_q);
            bc_q <= wr_busy ? bc_q + 32'h1 : 32'h0;
            if (wr_busy && bc_q == 32'h0) begin
                pg_q <= wr_pages;
            end
        end
    end
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    chk_idle_seen: assert property (hi_q >= 8'h0f |-> bus_idle)
        else $error("bus not idle with both lines high");
    chk_start_pins: assert property (start_seen |-> scl_in && !sda_in && lo_q >= 8'h08)
        else $error("start without a long enough data fall under high clock");
    chk_stop_pins: assert property (stop_seen |-> scl_in && sda_in)
        else $error("stop without data high under high clock");
    chk_rx_clock_high: assert property (rx_byte.valid |-> scl_in)
        else $error("byte taken while clock low");
    chk_pull_delay: assert property ($fell(sda_oe_n) |-> sl_q >= 8'h26)
        else $error("data pulled too soon after clock fall");
    chk_release_point: assert property ($rose(sda_oe_n) |-> scl_in || sl_q >= 8'h26)
        else $error("data released too soon after clock fall");
    chk_cond_release: assert property (start_seen || stop_seen |=> sda_oe_n)
        else $error("data held after a bus condition");
    chk_busy_quiet: assert property (wr_busy |-> sda_oe_n)
        else $error("data driven during write cycle");
    chk_busy_length: assert property ($fell(wr_busy) |-> bc_q >= pg_q * WR_CYCLES_PER_PAGE &&
        bc_q <= pg_q * WR_CYCLES_PER_PAGE + 1)
        else $error("write cycle length wrong");
    cover property (start_seen);
    cover property (stop_seen);
    cover property ($fell(sda_oe_n));
    cover property ($rose(wr_busy));
endmodule : eeprom_bus_cond_sva

bind eeprom_bus_cond eeprom_bus_cond_sva #(.WR_CYCLES_PER_PAGE(WR_CYCLES_PER_PAGE)) i_eeprom_bus_cond_sva (
    .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n), .wr_pages(wr_pages),
    .rx_byte(rx_byte), .start_seen(start_seen), .stop_seen(stop_seen), .bus_idle(bus_idle), .wr_busy(wr_busy));

// ### bench/bus_master.sv
// Behavioural two-wire bus master: makes the clock and frames every transfer.
`timescale 1ns/1ns
module bus_master (
    input wire logic clock,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    // ********
    // Bus phases
    // ********
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask : hold
    // Low phase is long so the device's delayed drive settles before the rise.
    task automatic bit_x(input logic b, output logic r);
        scl <= 1'b0;
        hold(4);
        sda_drv <= b;
        hold(76);
        scl <= 1'b1;
        hold(48);
        r = sda_line;
    endtask : bit_x
    // A start when first is high, otherwise a stop.
    task automatic cond(input logic first);
        scl <= 1'b0;
        hold(4);
        sda_drv <= first;
        hold(76);
        scl <= 1'b1;
        hold(48);
        sda_drv <= !first;
        hold(80);
    endtask : cond
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(mack, r);
        ack = !r;
    endtask : xfer
    task automatic glitch(input int n);
        sda_drv <= 1'b0;
        hold(n);
        sda_drv <= 1'b1;
        hold(40);
    endtask : glitch
endmodule : bus_master

// ### bench/eeprom_two_wire_bus_conditions_tb.sv
// Self-checking bench around the two-wire bus condition block.
`timescale 1ns/1ns
module eeprom_two_wire_bus_conditions_tb;
    localparam int WR = 200;
    logic clock = 1'b0;
    logic nrst;
    logic ack_en;
    logic tx_en;
    logic [7:0] tx_data;
    logic [3:0] wr_pages;
    logic [7:0] rx_last = 8'h00;
    logic scl, sda_drv, sda_out, sda_oe_n, tx_load, start_seen, stop_seen, bus_idle, wr_busy;
    eeprom_bus_pkg::rx_byte_s rx_byte;
    wire sda_line;
    int n_fail = 0, checked = 0, n_start = 0, n_stop = 0, n_load = 0, busy_n = 0, cyc = 0;
    integer seed = 42111;
    assign sda_line = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
    always #4 clock = ~clock;
    bus_master i_bus_master (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    eeprom_bus_cond #(.WR_CYCLES_PER_PAGE(WR)) i_eeprom_bus_cond (
        .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .ack_en(ack_en), .tx_en(tx_en), .tx_data(tx_data), .wr_pages(wr_pages), .rx_byte(rx_byte),
        .tx_load(tx_load), .start_seen(start_seen), .stop_seen(stop_seen), .bus_idle(bus_idle), .wr_busy(wr_busy));
    function automatic int exp_busy(input int p);
        return p * WR;
    endfunction : exp_busy
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    always @(posedge clock) begin
        cyc++;
        if (start_seen === 1'b1) n_start++;
        if (stop_seen === 1'b1) n_stop++;
        if (tx_load === 1'b1) n_load++;
        if (wr_busy === 1'b1) busy_n++;
        if (rx_byte.valid === 1'b1) rx_last = rx_byte.data;
        if (cyc == 30000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        logic [7:0] d, q;
        logic a;
        int p, n, b;
        nrst <= 1'b0;
        ack_en <= 1'b1;
        tx_en <= 1'b0;
        tx_data <= 8'($random(seed));
        wr_pages <= 4'h0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        i_bus_master.hold(20);
        chk({7'h00, bus_idle}, 8'h01);
        n = n_start;
        i_bus_master.glitch(6);
        chk(8'(n_start - n), 8'h00);
        $display("test idle and spike done");
        p = 7 + ($random(seed) & 1);
        wr_pages <= 4'(p);
        i_bus_master.cond(1'b1);
        chk(8'(n_start - n), 8'h01);
        for (int k = 0; k < 3; k++) begin
            d = 8'($random(seed));
            i_bus_master.xfer(d, 1'b1, q, a);
            chk(rx_last, d);
            chk({7'h00, a}, 8'h01);
        end
        n = n_stop;
        b = busy_n;
        i_bus_master.cond(1'b0);
        chk(8'(n_stop - n), 8'h01);
        chk({7'h00, wr_busy}, 8'h01);
        wr_pages <= 4'h0;
        i_bus_master.cond(1'b1);
        i_bus_master.xfer(8'($random(seed)), 1'b1, q, a);
        chk({7'h00, a}, 8'h00);
        i_bus_master.cond(1'b0);
        for (int k = 0; k < 2000 && wr_busy !== 1'b0; k++) @(posedge clock);
        chk(8'(busy_n - b - exp_busy(p)) & 8'hfe, 8'h00);
        $display("test write and poll done");
        d = 8'($random(seed));
        tx_data <= d;
        tx_en <= 1'b1;
        n = n_load;
        i_bus_master.cond(1'b1);
        i_bus_master.xfer(8'($random(seed)), 1'b1, q, a);
        i_bus_master.xfer(8'hff, 1'b0, q, a);
        chk(q, d);
        d = 8'($random(seed));
        tx_data <= d;
        i_bus_master.xfer(8'hff, 1'b1, q, a);
        chk(q, d);
        chk(8'(n_load - n), 8'h02);
        i_bus_master.cond(1'b0);
        tx_en <= 1'b0;
        $display("test read done");
        n = n_start;
        i_bus_master.cond(1'b1);
        for (int k = 0; k < 4; k++) i_bus_master.bit_x(seed[k], a);
        i_bus_master.cond(1'b1);
        d = 8'($random(seed));
        i_bus_master.xfer(d, 1'b1, q, a);
        chk(rx_last, d);
        chk(8'(n_start - n), 8'h02);
        ack_en <= 1'b0;
        i_bus_master.xfer(d, 1'b1, q, a);
        chk({7'h00, a}, 8'h00);
        ack_en <= 1'b1;
        i_bus_master.cond(1'b0);
        $display("test restart and refusal done");
        conclude();
    end
endmodule : eeprom_two_wire_bus_conditions_tb
